// ### test/sclks_osc_model.sv
// Oscillator model: one tick per source cycle while enabled
`timescale 1ns/1ns
module sclks_osc_model (
    input  wire logic       i_clk,
    input  wire logic [4:0] i_osc_enable,
    output logic      [4:0] o_ticks
);
    int cnt_q = 0;
    always @(posedge i_clk) begin
        cnt_q <= cnt_q + 1;
        for (int k = 0; k < 5; k++)
            o_ticks[k] <= i_osc_enable[k] && (cnt_q % (k + 2) == 0);
    end
endmodule : sclks_osc_model

// ### test/sclks_top_asserts.sv
// Port checker for the system clock source selector
`timescale 1ns/1ns
module sclks_top_asserts (
    input wire logic       i_clk,
    input wire logic       i_nrst,
    input wire logic [7:0] i_factory_trim,
    input wire logic       i_tick_wdt,
    input wire logic       i_tick_ext,
    input wire logic       i_tick_lfx,
    input wire logic       i_async_from_ext,
    input wire logic       i_ext_irq,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_rc_trim,
    input wire logic       o_core_clk_en,
    input wire logic       o_peripheral_clk_en,
    input wire logic       o_program_memory_clk_en,
    input wire logic       o_converter_clk_en,
    input wire logic       o_wdt_clk_en,
    input wire logic       o_async_timer_clk_en,
    input wire logic       o_cpu_run,
    input wire logic       o_ext_irq_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
    chk_wdt_copy: assert property ($past(i_nrst) |-> o_wdt_clk_en == $past(i_tick_wdt))
        else $error("wdt tick lost");
    chk_async_copy: assert property ($past(i_nrst) |->
        o_async_timer_clk_en == $past(i_async_from_ext ? i_tick_ext : i_tick_lfx)) else $error("async tick lost");
    chk_flash_core: assert property (o_program_memory_clk_en == o_core_clk_en) else $error("flash apart");
    chk_core_periph: assert property (o_core_clk_en |-> o_peripheral_clk_en) else $error("core without io");
    chk_periph_conv: assert property (o_peripheral_clk_en |-> o_converter_clk_en) else $error("converter off");
    chk_irq_sticky: assert property ($past(i_ext_irq) && $past(i_nrst) |-> o_ext_irq_flag)
        else $error("irq missed");
    chk_trim_load: assert property (!$past(i_nrst, 2) && $past(i_nrst) |-> o_rc_trim == $past(i_factory_trim))
        else $error("trim not loaded");
    chk_trim_write: assert property ($past(i_wr) && $past(i_addr) == sclks_pkg::ADDR_RC_TRIM && $past(i_nrst)
        |-> o_rc_trim == $past(i_wdata)) else $error("trim not written");
    cover property ($rose(o_cpu_run));
    cover property (o_ext_irq_flag);
    cover property (o_converter_clk_en && !o_core_clk_en);
endmodule : sclks_top_asserts
bind sclks_top sclks_top_asserts sclks_top_asserts_inst (
    .i_clk, .i_nrst, .i_factory_trim, .i_tick_wdt, .i_ext_irq, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_rc_trim, .o_core_clk_en, .o_peripheral_clk_en, .o_program_memory_clk_en, .o_converter_clk_en,
    .o_wdt_clk_en, .o_cpu_run, .o_ext_irq_flag, .i_tick_ext, .i_tick_lfx, .i_async_from_ext, .o_async_timer_clk_en);

// ### test/tb_top.sv
// Self-checking bench for the system clock source selector
`timescale 1ns/1ns
module tb_top;
    logic       i_clk = 1'b0;
    logic       i_nrst = 1'b0;
    logic [7:0] fuse = 8'hA2;
    logic [7:0] i_factory_trim = 8'h00;
    logic [1:0] i_sleep_mode = 2'h0;
    logic       i_ext_irq = 1'b0;
    logic       i_async_from_ext = 1'b0;
    logic       o_async_timer_clk_en;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic [7:0] o_rdata, rv, d;
    logic [4:0] o_osc_enable, ticks;
    logic       o_core_clk_en, o_peripheral_clk_en, o_converter_clk_en, o_cpu_run;
    int         failures = 0, compares = 0, seed = 49, n, nc, np, nv, na;
    logic [3:0] codes [8] = '{4'h3, 4'h0, 4'h4, 4'h8, 4'hA, 4'hC, 4'hE, 4'h2};
    always #25 i_clk = ~i_clk;
    sclks_osc_model sclks_osc_model_inst (.i_clk, .i_osc_enable(o_osc_enable), .o_ticks(ticks));
    sclks_top #(.P_WDT_LONG_CYC(16'h0010), .P_XTAL_SLOW_CYC(16'h0010), .P_LFX_SLOW_CYC(16'h0010)) sclks_top_inst (
        .i_clk, .i_nrst, .i_source_select_fuses(fuse[3:0]), .i_startup_select_fuses(fuse[5:4]),
        .i_divide_by_eight_fuse(fuse[6]), .i_reset_pin_disable_fuse(fuse[7]), .i_factory_trim,
        .i_tick_ext(ticks[0]), .i_tick_rc(ticks[1]), .i_tick_wdt(ticks[2]), .i_tick_lfx(ticks[3]),
        .i_tick_xtal(ticks[4]), .i_async_from_ext, .i_sleep_mode, .i_ext_irq, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .o_rc_trim(), .o_osc_enable, .o_core_clk_en, .o_peripheral_clk_en,
        .o_program_memory_clk_en(), .o_converter_clk_en, .o_async_timer_clk_en, .o_wdt_clk_en(),
        .o_cpu_run, .o_ext_irq_flag());
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // One register cycle; read data captured in the cycle after the strobe
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] dt);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= dt;
        i_wr <= w;
        i_rd <= !w;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask : acc
    task automatic run_wait();
        #1;
        for (n = 0; n < 6000 && o_cpu_run !== 1'b1; n++)
            #50;
        chk(o_cpu_run, 1'b1);
    endtask : run_wait
    task automatic rst(input logic [7:0] f);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        fuse <= f;
        i_factory_trim <= 8'($random(seed));
        repeat (16) @(posedge i_clk);
        i_nrst <= 1'b1;
        run_wait();
    endtask : rst
    // Counts domain enable pulses over 240 cycles
    task automatic meas();
        nc = 0;
        np = 0;
        nv = 0;
        na = 0;
        repeat (4) @(posedge i_clk);
        repeat (240) begin
            @(posedge i_clk);
            #1 nc += int'(o_core_clk_en);
            np += int'(o_peripheral_clk_en);
            nv += int'(o_converter_clk_en);
            na += int'(o_async_timer_clk_en);
        end
    endtask : meas
    function automatic int osc_bit(input logic [3:0] c);
        return c[3] ? 4 : c[2] ? 3 : c[1] ? int'(c[1:0]) - 1 : 0;
    endfunction : osc_bit
    initial begin
        #2000000 failures++;
        end_of_test();
    end
    initial begin
        rst(8'hA2);
        chk(n inside {[118:136]}, 1'b1);
        acc(1'b0, sclks_pkg::ADDR_SRC_SEL, 8'h00);
        chk(rv[5:0], 6'h22);
        acc(1'b0, sclks_pkg::ADDR_RC_TRIM, 8'h00);
        chk(rv, i_factory_trim);
        meas();
        chk(nc inside {[9:11]}, 1'b1);
        repeat (3) begin
            d = 8'($random(seed));
            acc(1'b1, sclks_pkg::ADDR_RC_TRIM, d);
            acc(1'b0, sclks_pkg::ADDR_RC_TRIM, 8'h00);
            chk(rv, d);
        end
        acc(1'b1, sclks_pkg::ADDR_SRC_SEL, 8'h01);
        acc(1'b0, sclks_pkg::ADDR_STATUS, 8'h00);
        chk(rv[2], 1'b1);
        acc(1'b1, sclks_pkg::ADDR_STATUS, 8'h04);
        acc(1'b0, sclks_pkg::ADDR_STATUS, 8'h00);
        chk(rv[2], 1'b0);
        foreach (codes[i]) begin
            acc(1'b1, sclks_pkg::ADDR_SRC_SEL, {4'h0, codes[i]});
            acc(1'b0, sclks_pkg::ADDR_STATUS, 8'h00);
            chk(rv[0], 1'b1);
            for (n = 0; n < 3000 && rv[0] !== 1'b0; n++)
                acc(1'b0, sclks_pkg::ADDR_STATUS, 8'h00);
            chk(o_osc_enable[osc_bit(codes[i])], 1'b1);
            acc(1'b0, sclks_pkg::ADDR_SRC_SEL, 8'h00);
            chk(rv[3:0], codes[i]);
        end
        for (int m = 0; m < 4; m++) begin
            i_sleep_mode <= 2'(m);
            i_async_from_ext <= m[0];
            meas();
            chk({nc > 0, np > 0, nv > 0, na > 0}, {m == 0, m < 2, m < 3, 1'b1});
        end
        i_ext_irq <= 1'b1;
        @(posedge i_clk);
        i_ext_irq <= 1'b0;
        acc(1'b0, sclks_pkg::ADDR_EXT_IRQ, 8'h00);
        chk(rv[0], 1'b1);
        acc(1'b1, sclks_pkg::ADDR_EXT_IRQ, 8'h01);
        acc(1'b0, sclks_pkg::ADDR_EXT_IRQ, 8'h00);
        chk(rv[0], 1'b0);
        i_sleep_mode <= 2'h0;
        repeat (3) @(posedge i_clk);
        #1 chk(o_cpu_run, 1'b0);
        run_wait();
        rst(8'h43);
        chk(n inside {[2120:2145]}, 1'b1);
        acc(1'b0, sclks_pkg::ADDR_SRC_SEL, 8'h00);
        chk(rv[5:0], 6'h13);
        meas();
        chk(nc inside {[59:61]}, 1'b1);
        end_of_test();
    end
endmodule : tb_top

// ### verilog/sclks_pkg.sv
// Constants and types for the system clock source selector
package sclks_pkg;

    // ==================================================================
    // Register map (8-bit data, word index equals address)
    // ==================================================================
    localparam logic [1:0] ADDR_SRC_SEL   = 2'h0;
    localparam logic [1:0] ADDR_RC_TRIM   = 2'h1;
    localparam logic [1:0] ADDR_STATUS    = 2'h2;
    localparam logic [1:0] ADDR_EXT_IRQ   = 2'h3;

    // Dynamic source select register fields
    localparam int FLD_SRC_LSB     = 0;
    localparam int FLD_SUT_LSB     = 4;
    localparam int FLD_DIV8_BIT    = 6;
    // Status register fields
    localparam int FLD_BUSY_BIT    = 0;
    localparam int FLD_RUN_BIT     = 1;
    localparam int FLD_REFUSED_BIT = 2;
    localparam int FLD_DIV8_ST_BIT = 3;
    // External interrupt register field
    localparam int FLD_IRQ_BIT     = 0;

    // ==================================================================
    // Source select codes
    // ==================================================================
    localparam logic [3:0] CODE_EXT_CLK   = 4'h0;
    localparam logic [3:0] CODE_RC_8M     = 4'h2;
    localparam logic [3:0] CODE_WDT_128K  = 4'h3;
    localparam logic [1:0] CODE_LFX_TOP   = 2'h1;
    localparam logic [3:0] RST_SRC_CODE   = 4'h2;

    // Start-up select codes
    localparam logic [1:0] SUT_SHORT      = 2'h0;
    localparam logic [1:0] SUT_MID        = 2'h1;
    localparam logic [1:0] SUT_LONG       = 2'h2;
    localparam logic [1:0] SUT_RSVD       = 2'h3;
    localparam logic [1:0] RST_SUT        = 2'h2;

    // Fuse level meaning
    localparam logic       FUSE_PROGRAMMED = 1'b0;

    // ==================================================================
    // Timing counts, in cycles of the timing source
    // ==================================================================
    localparam logic [15:0] CK_RC_START    = 16'h0006;
    localparam logic [15:0] CK_RESET_ADD   = 16'h000E;
    localparam logic [15:0] CK_XTAL_FAST   = 16'h0102;
    localparam logic [15:0] CK_OSC_MID     = 16'h0400;
    localparam logic [15:0] WDT_SHORT_CYC  = 16'h0200;
    localparam logic [15:0] WDT_LONG_CYC   = 16'h2000;
    localparam logic [15:0] XTAL_SLOW_CYC  = 16'h4000;
    localparam logic [15:0] LFX_SLOW_CYC   = 16'h8000;
    localparam logic [2:0]  DIV8_LAST      = 3'h7;
    localparam logic [7:0]  RST_TRIM       = 8'h00;

    // Sleep modes
    localparam logic [1:0]  MODE_ACTIVE    = 2'h0;
    localparam logic [1:0]  MODE_IDLE      = 2'h1;
    localparam logic [1:0]  MODE_ADC_NR    = 2'h2;
    localparam logic [1:0]  MODE_PWR_DOWN  = 2'h3;

    // Oscillator kinds
    typedef enum logic [2:0] {
        OSC_EXT, OSC_RC, OSC_WDT, OSC_LFX, OSC_XTAL, OSC_NONE
    } sclks_osc_e;

    typedef enum logic [2:0] {
        ST_CAPTURE, ST_START, ST_RST_WDT, ST_RST_CK, ST_RUN, ST_WAKE, ST_SWITCH
    } sclks_state_e;

endpackage : sclks_pkg

// ### verilog/sclks_top.sv
// System clock source selection, start-up timing and domain enables
`timescale 1ns/1ns
module sclks_top #(
    parameter logic [15:0] P_WDT_LONG_CYC  = sclks_pkg::WDT_LONG_CYC,
    parameter logic [15:0] P_XTAL_SLOW_CYC = sclks_pkg::XTAL_SLOW_CYC,
    parameter logic [15:0] P_LFX_SLOW_CYC  = sclks_pkg::LFX_SLOW_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic [3:0] i_source_select_fuses,
    input  wire logic [1:0] i_startup_select_fuses,
    input  wire logic       i_divide_by_eight_fuse,
    input  wire logic       i_reset_pin_disable_fuse,
    input  wire logic [7:0] i_factory_trim,
    input  wire logic       i_tick_ext,
    input  wire logic       i_tick_rc,
    input  wire logic       i_tick_wdt,
    input  wire logic       i_tick_lfx,
    input  wire logic       i_tick_xtal,
    input  wire logic       i_async_from_ext,
    input  wire logic [1:0] i_sleep_mode,
    input  wire logic       i_ext_irq,
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    output logic      [7:0] o_rc_trim,
    output logic      [4:0] o_osc_enable,
    output logic            o_core_clk_en,
    output logic            o_peripheral_clk_en,
    output logic            o_program_memory_clk_en,
    output logic            o_converter_clk_en,
    output logic            o_async_timer_clk_en,
    output logic            o_wdt_clk_en,
    output logic            o_cpu_run,
    output logic            o_ext_irq_flag
);

    // ==================================================================
    // Elaboration checks
    // ==================================================================
    if (P_WDT_LONG_CYC == 16'h0000 || P_XTAL_SLOW_CYC == 16'h0000 || P_LFX_SLOW_CYC == 16'h0000) begin : g_bad_counts
        $error("sclks_top: start-up counts must be nonzero");
    end

    // ==================================================================
    // Functions
    // ==================================================================
    // Source code decode
    function automatic sclks_pkg::sclks_osc_e osc_of(input logic [3:0] code);
        if (code == sclks_pkg::CODE_EXT_CLK) begin
            osc_of = sclks_pkg::OSC_EXT;
        end else if (code == sclks_pkg::CODE_RC_8M) begin
            osc_of = sclks_pkg::OSC_RC;
        end else if (code == sclks_pkg::CODE_WDT_128K) begin
            osc_of = sclks_pkg::OSC_WDT;
        end else if (code[3:2] == sclks_pkg::CODE_LFX_TOP) begin
            osc_of = sclks_pkg::OSC_LFX;
        end else if (code[3]) begin
            osc_of = sclks_pkg::OSC_XTAL;
        end else begin
            osc_of = sclks_pkg::OSC_NONE;
        end
    endfunction : osc_of

    function automatic logic tick_of(input logic [3:0] code, input logic [4:0] ticks);
        sclks_pkg::sclks_osc_e k;
        k = osc_of(code);
        tick_of = (k == sclks_pkg::OSC_NONE) ? 1'b0 : ticks[k];
    endfunction : tick_of

    // Short start-up refused with the reset pin disabled
    function automatic logic [1:0] legal_sut(input logic [1:0] startup_select_fuses, input logic rpd_fuse);
        legal_sut = startup_select_fuses;
        if (startup_select_fuses == sclks_pkg::SUT_SHORT && rpd_fuse == sclks_pkg::FUSE_PROGRAMMED) begin
            legal_sut = sclks_pkg::SUT_MID;
        end
    endfunction : legal_sut

    // Start-up count in cycles of the selected source
    function automatic logic [15:0] start_cnt(input logic [3:0] code, input logic [1:0] startup_select_fuses);
        start_cnt = sclks_pkg::CK_RC_START;
        unique case (osc_of(code))
            sclks_pkg::OSC_LFX: begin
                start_cnt = (startup_select_fuses == sclks_pkg::SUT_LONG) ? P_LFX_SLOW_CYC : sclks_pkg::CK_OSC_MID;
            end
            sclks_pkg::OSC_XTAL: begin
                if (code[0]) begin
                    start_cnt = (startup_select_fuses == sclks_pkg::SUT_SHORT) ? sclks_pkg::CK_OSC_MID : P_XTAL_SLOW_CYC;
                end else if (startup_select_fuses[1]) begin
                    start_cnt = sclks_pkg::CK_OSC_MID;
                end else begin
                    start_cnt = sclks_pkg::CK_XTAL_FAST;
                end
            end
            // RC, watchdog and external clock start in 6 CK
            default: begin
                start_cnt = sclks_pkg::CK_RC_START;
            end
        endcase
    endfunction : start_cnt

    // Watchdog oscillator cycles added after reset
    function automatic logic [15:0] reset_wdt_cnt(input logic [1:0] startup_select_fuses);
        unique case (startup_select_fuses)
            sclks_pkg::SUT_SHORT: reset_wdt_cnt = 16'h0000;
            sclks_pkg::SUT_MID:   reset_wdt_cnt = sclks_pkg::WDT_SHORT_CYC;
            default:              reset_wdt_cnt = P_WDT_LONG_CYC;
        endcase
    endfunction : reset_wdt_cnt

    // ==================================================================
    // State
    // ==================================================================
    typedef struct packed {
        sclks_pkg::sclks_state_e st;
        logic [15:0]             cnt;
        logic [3:0]              src;
        logic [1:0]              startup_select_fuses;
        logic [3:0]              act_src;
        logic                    div8;
        logic [2:0]              pre;
        logic                    refused;
        logic                    irq;
        logic [7:0]              trim;
        logic [1:0]              last_mode;
        logic [7:0]              rdata;
        logic [4:0]              osc_en;
        logic                    core_en;
        logic                    io_en;
        logic                    flash_en;
        logic                    adc_en;
        logic                    asy_en;
        logic                    wdt_en;
        logic                    run;
    } sclks_state_s;

    sclks_state_s state_q;
    sclks_state_s state_d;

    logic [4:0] ticks;
    assign ticks = {i_tick_xtal, i_tick_lfx, i_tick_wdt, i_tick_rc, i_tick_ext};

    // ==================================================================
    // Next state
    // ==================================================================
    always_comb begin
        logic        act_tick;
        logic        new_tick;
        logic        sys_tick;
        logic        running;
        logic        wr_sel;
        logic [1:0]  mode;
        state_d  = state_q;
        sys_tick = 1'b0;
        running  = 1'b0;
        act_tick = tick_of(state_q.act_src, ticks);
        new_tick = tick_of(state_q.src, ticks);
        mode     = i_sleep_mode;
        wr_sel   = i_wr && i_addr == sclks_pkg::ADDR_SRC_SEL;
        state_d.last_mode = mode;

        unique case (state_q.st)
            // Catch fuse values after reset release
            sclks_pkg::ST_CAPTURE: begin
                state_d.src     = i_source_select_fuses;
                state_d.act_src = i_source_select_fuses;
                if (osc_of(i_source_select_fuses) == sclks_pkg::OSC_NONE) begin
                    state_d.src     = sclks_pkg::RST_SRC_CODE;
                    state_d.act_src = sclks_pkg::RST_SRC_CODE;
                end
                state_d.startup_select_fuses = legal_sut(i_startup_select_fuses, i_reset_pin_disable_fuse);
                if (i_startup_select_fuses == sclks_pkg::SUT_RSVD) begin
                    state_d.startup_select_fuses = sclks_pkg::SUT_LONG;
                end
                // Programmed fuse reads as 0 and selects divide by 8
                state_d.div8 = i_divide_by_eight_fuse == sclks_pkg::FUSE_PROGRAMMED;
                state_d.trim = i_factory_trim;
                state_d.cnt  = start_cnt(state_d.act_src, state_d.startup_select_fuses) - 16'h0001;
                state_d.st   = sclks_pkg::ST_START;
            end
            sclks_pkg::ST_START: begin
                if (act_tick) begin
                    state_d.cnt = state_q.cnt - 16'h0001;
                    if (state_q.cnt == 16'h0000) begin
                        state_d.cnt = reset_wdt_cnt(state_q.startup_select_fuses) - 16'h0001;
                        state_d.st  = (state_q.startup_select_fuses == sclks_pkg::SUT_SHORT) ?
                                      sclks_pkg::ST_RST_CK : sclks_pkg::ST_RST_WDT;
                        if (state_q.startup_select_fuses == sclks_pkg::SUT_SHORT) begin
                            state_d.cnt = sclks_pkg::CK_RESET_ADD - 16'h0001;
                        end
                    end
                end
            end
            // Reset time-out timed by the watchdog oscillator
            sclks_pkg::ST_RST_WDT: begin
                if (i_tick_wdt) begin
                    state_d.cnt = state_q.cnt - 16'h0001;
                    if (state_q.cnt == 16'h0000) begin
                        state_d.cnt = sclks_pkg::CK_RESET_ADD - 16'h0001;
                        state_d.st  = sclks_pkg::ST_RST_CK;
                    end
                end
            end
            // Final 14 CK of the reset delay
            sclks_pkg::ST_RST_CK: begin
                if (act_tick) begin
                    state_d.cnt = state_q.cnt - 16'h0001;
                    if (state_q.cnt == 16'h0000) begin
                        state_d.st = sclks_pkg::ST_RUN;
                    end
                end
            end
            sclks_pkg::ST_RUN: begin
                // Leaving power-down restarts the active source
                if (state_q.last_mode == sclks_pkg::MODE_PWR_DOWN && mode != sclks_pkg::MODE_PWR_DOWN) begin
                    state_d.cnt = start_cnt(state_q.act_src, state_q.startup_select_fuses) - 16'h0001;
                    state_d.st  = sclks_pkg::ST_WAKE;
                end else if (wr_sel) begin
                    state_d.div8 = i_wdata[sclks_pkg::FLD_DIV8_BIT];
                    if (osc_of(i_wdata[sclks_pkg::FLD_SRC_LSB +: 4]) == sclks_pkg::OSC_NONE) begin
                        state_d.refused = 1'b1;
                    end else begin
                        state_d.src = i_wdata[sclks_pkg::FLD_SRC_LSB +: 4];
                        state_d.startup_select_fuses = legal_sut(i_wdata[sclks_pkg::FLD_SUT_LSB +: 2], i_reset_pin_disable_fuse);
                        state_d.cnt = start_cnt(state_d.src, state_d.startup_select_fuses) - 16'h0001;
                        state_d.st  = sclks_pkg::ST_SWITCH;
                    end
                end
            end
            sclks_pkg::ST_WAKE: begin
                if (act_tick) begin
                    state_d.cnt = state_q.cnt - 16'h0001;
                    if (state_q.cnt == 16'h0000) begin
                        state_d.st = sclks_pkg::ST_RUN;
                    end
                end
            end
            // Old source keeps running until the new one has started
            sclks_pkg::ST_SWITCH: begin
                if (new_tick) begin
                    state_d.cnt = state_q.cnt - 16'h0001;
                    if (state_q.cnt == 16'h0000) begin
                        state_d.act_src = state_q.src;
                        state_d.pre     = 3'h0;
                        state_d.st      = sclks_pkg::ST_RUN;
                    end
                end
            end
        endcase

        if (wr_sel && state_q.st != sclks_pkg::ST_RUN) begin
            state_d.refused = 1'b1;
        end

        // Trim register writable in every state except ST_CAPTURE
        if (i_wr && i_addr == sclks_pkg::ADDR_RC_TRIM && state_q.st != sclks_pkg::ST_CAPTURE) begin
            state_d.trim = i_wdata;
        end
        // Refused flag cleared by writing one, new refusal wins
        if (i_wr && i_addr == sclks_pkg::ADDR_STATUS && i_wdata[sclks_pkg::FLD_REFUSED_BIT] && !(wr_sel)) begin
            state_d.refused = 1'b0;
        end
        // External interrupt caught regardless of clock domain state
        if (i_wr && i_addr == sclks_pkg::ADDR_EXT_IRQ && i_wdata[sclks_pkg::FLD_IRQ_BIT]) begin
            state_d.irq = 1'b0;
        end
        if (i_ext_irq) begin
            state_d.irq = 1'b1;
        end

        if (act_tick) begin
            state_d.pre = (state_d.st == sclks_pkg::ST_SWITCH || state_q.st == state_d.st) ?
                          state_q.pre + 3'h1 : state_d.pre;
        end
        sys_tick = act_tick && (!state_q.div8 || state_q.pre == sclks_pkg::DIV8_LAST);
        running  = state_q.st == sclks_pkg::ST_RUN || state_q.st == sclks_pkg::ST_SWITCH;

        state_d.run     = running;
        state_d.core_en = sys_tick && running && mode == sclks_pkg::MODE_ACTIVE;
        // Program memory clock follows the core clock
        state_d.flash_en = sys_tick && running && mode == sclks_pkg::MODE_ACTIVE;
        state_d.io_en   = sys_tick && running &&
                          (mode == sclks_pkg::MODE_ACTIVE || mode == sclks_pkg::MODE_IDLE);
        state_d.adc_en  = sys_tick && running && mode != sclks_pkg::MODE_PWR_DOWN;
        // Async timer from its own source, also while asleep
        state_d.asy_en  = i_async_from_ext ? i_tick_ext : i_tick_lfx;
        // Watchdog clock always from the watchdog oscillator
        state_d.wdt_en  = i_tick_wdt;

        state_d.osc_en = 5'h00;
        if (osc_of(state_d.act_src) != sclks_pkg::OSC_NONE && mode != sclks_pkg::MODE_PWR_DOWN) begin
            state_d.osc_en[osc_of(state_d.act_src)] = 1'b1;
        end
        if (state_d.st == sclks_pkg::ST_SWITCH) begin
            state_d.osc_en[osc_of(state_d.src)] = 1'b1;
        end
        if (state_d.st == sclks_pkg::ST_WAKE || state_d.st == sclks_pkg::ST_START) begin
            state_d.osc_en[osc_of(state_d.act_src)] = 1'b1;
        end
        state_d.osc_en[sclks_pkg::OSC_WDT] = 1'b1;
        if (i_async_from_ext) begin
            state_d.osc_en[sclks_pkg::OSC_EXT] = 1'b1;
        end else begin
            state_d.osc_en[sclks_pkg::OSC_LFX] = 1'b1;
        end

        // Read data, valid the cycle after the strobe
        state_d.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                sclks_pkg::ADDR_SRC_SEL: state_d.rdata = {1'b0, state_q.div8, state_q.startup_select_fuses, state_q.src};
                sclks_pkg::ADDR_RC_TRIM: state_d.rdata = state_q.trim;
                sclks_pkg::ADDR_STATUS:  state_d.rdata = {4'h0, state_q.div8, state_q.refused,
                                                          running, state_q.st != sclks_pkg::ST_RUN};
                sclks_pkg::ADDR_EXT_IRQ: state_d.rdata = {7'h00, state_q.irq};
            endcase
        end
    end

    // ==================================================================
    // Registers
    // ==================================================================
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q         <= '0;
            state_q.st      <= sclks_pkg::ST_CAPTURE;
            state_q.src     <= sclks_pkg::RST_SRC_CODE;
            state_q.act_src <= sclks_pkg::RST_SRC_CODE;
            state_q.startup_select_fuses     <= sclks_pkg::RST_SUT;
            state_q.div8    <= 1'b1;
            state_q.trim    <= sclks_pkg::RST_TRIM;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_rdata                 = state_q.rdata;
    assign o_rc_trim               = state_q.trim;
    assign o_osc_enable            = state_q.osc_en;
    assign o_core_clk_en           = state_q.core_en;
    assign o_peripheral_clk_en     = state_q.io_en;
    assign o_program_memory_clk_en = state_q.flash_en;
    assign o_converter_clk_en      = state_q.adc_en;
    assign o_async_timer_clk_en    = state_q.asy_en;
    assign o_wdt_clk_en            = state_q.wdt_en;
    assign o_cpu_run               = state_q.run;
    assign o_ext_irq_flag          = state_q.irq;

endmodule : sclks_top
